/* File: atomic_rmw_pkg.sv */
package atomic_rmw_pkg;

	typedef enum logic [2:0] {
		ST_CMD,
		ST_EXT,
		ST_HDR,
		ST_PAY,
		ST_EXEC,
		ST_RESP
	} state_t;

	// Packet command codes
	localparam logic [5:0] CMD_ATOMIC    = 6'h3D;
	localparam logic [5:0] CMD_ADDR_EXT  = 6'h3E;
	localparam logic [5:0] CMD_RD_REPLY  = 6'h30;

	// Size field values
	localparam logic [3:0] CNT_FETCH_ADD = 4'h1;
	localparam logic [3:0] CNT_CMP_SWAP  = 4'h3;
	localparam logic [3:0] RESP_COUNT    = 4'h1;

	// Error encodings as {error_bit_high, error_bit_low}
	localparam logic [1:0] ERR_NONE      = 2'h0;
	localparam logic [1:0] ERR_TGT_ABORT = 2'h1;

	// Implied attribute bits of an atomic request; bridge bit of its reply
	localparam logic       IMPLIED_COHERENT  = 1'h1;
	localparam logic       IMPLIED_ISOC      = 1'h0;
	localparam logic       IMPLIED_RESP_PASS = 1'h0;
	localparam logic       RESP_BRIDGE       = 1'h1;

	// Last byte indexes of packets; reply header length in bytes
	localparam logic [3:0] EXT_LAST_IDX  = 4'h2;
	localparam logic [3:0] HDR_LAST_IDX  = 4'h7;
	localparam logic [3:0] RESP_LAST_IDX = 4'hB;
	localparam logic [3:0] RESP_HDR_LEN  = 4'h4;

	// Backing quadword store
	localparam int         MEM_DEPTH = 16;
	localparam int         MEM_AW    = 4;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_WINDOW = 8'h08;
	localparam logic [7:0] REG_MIDX   = 8'h0C;
	localparam logic [7:0] REG_MLO    = 8'h10;
	localparam logic [7:0] REG_MHI    = 8'h14;
	localparam logic [7:0] REG_COUNTS = 8'h18;

	// Control fields and reset values
	localparam int          CTRL_EN_BIT    = 0;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
	localparam logic [31:0] WINDOW_RESET   = 32'h0000_0000;
	localparam logic [31:0] MIDX_RESET     = 32'h0000_0000;

endpackage : atomic_rmw_pkg

/* File: atomic_rmw_target.sv */
`timescale 1ns/1ns
// Overview of operation
// - Atomic request is code 111101, eight bytes, split size.
// - Quadword aligned; address bits 39..3 carried.
// - Fetch-add returns old value, stores wrapping sum.
// - Compare-swap returns old, writes input on match.
// - Read and write indivisible; bus locked out.
// - Size selects operation; payload length always from size.
// - Size field is doublewords minus one.
// - Answered by one-quadword read reply with old value.
// - Reply size field is always 1.
// - Atomics disabled gives target-abort reply.
// - Target abort is high error 0, low 1.
// - Address outside host window gets target abort.
// - Coherent, non-isochronous, reply may not pass posted.
// - Extension doubleword supplies address bits 63..40.
// - Nothing between extension and its request.
// - Extension and request handled as one request.
// - No extension means upper address bits zero.
module atomic_rmw_target (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        rxValid,
	input  wire logic [7:0]  rxData,
	output logic             rxReady,
	output logic             txValid,
	output logic [7:0]       txData,
	input  wire logic        txReady,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o
);

	function automatic logic [31:0] mergeSel(input logic [31:0] old,
		input logic [31:0] wdat, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = wdat[b*8 +: 8];
			end
		end
		return res;
	endfunction : mergeSel

	// Reply byte builder: four header bytes then data, low byte first
	function automatic logic [7:0] replyByte(input logic [3:0] idx,
		input logic [4:0] stream_unit_id, input logic [4:0] source_transaction_tag,
		input logic [1:0] err, input logic [63:0] val);
		logic [7:0] res;
		res = 8'h00;
		unique case (idx)
			4'h0: res = {atomic_rmw_pkg::IMPLIED_ISOC, 1'h0,
				atomic_rmw_pkg::CMD_RD_REPLY};
			4'h1: res = {atomic_rmw_pkg::IMPLIED_RESP_PASS,
				atomic_rmw_pkg::RESP_BRIDGE, 1'h0, stream_unit_id};
			4'h2: res = {atomic_rmw_pkg::RESP_COUNT[1:0], err[0],
				source_transaction_tag};
			4'h3: res = {2'h0, err[1], 3'h0,
				atomic_rmw_pkg::RESP_COUNT[3:2]};
			default: res = val[(idx - atomic_rmw_pkg::RESP_HDR_LEN)*8 +: 8];
		endcase
		return res;
	endfunction : replyByte

	logic [63:0] mem [atomic_rmw_pkg::MEM_DEPTH];

	atomic_rmw_pkg::state_t state_r, state_nxt;
	logic [3:0]  idx_r, idx_nxt;
	logic [5:0]  payIdx_r, payIdx_nxt;
	logic        extSeen_r, extSeen_nxt;
	logic [23:0] addrHi_r, addrHi_nxt;
	logic [39:3] addrLo_r, addrLo_nxt;
	logic [3:0]  count_r, count_nxt;
	logic [4:0]  stream_unit_id_r, stream_unit_id_nxt;
	logic [4:0]  source_transaction_tag_r, source_transaction_tag_nxt;
	logic [63:0] opA_r, opA_nxt;
	logic [63:0] opB_r, opB_nxt;
	logic [63:0] outVal_r, outVal_nxt;
	logic [1:0]  err_r, err_nxt;
	logic [15:0] doneCnt_r, doneCnt_nxt;
	logic [15:0] abortCnt_r, abortCnt_nxt;
	logic        rxReady_r, rxReady_nxt;
	logic        txValid_r, txValid_nxt;
	logic [7:0]  txData_r, txData_nxt;

	logic [31:0] ctrl_r, ctrl_nxt;
	logic [31:0] window_r, window_nxt;
	logic [31:0] midx_r, midx_nxt;
	logic [31:0] datO_r, datO_nxt;
	logic        ack_r, ack_nxt;

	logic        rxTake;
	logic        txTake;
	logic [6:0]  payBytes;
	logic        inHost;
	logic        abortReq;
	logic [63:0] memOld;
	logic        engWe;
	logic [63:0] engWData;
	logic        busReq;
	logic        busWr;
	logic [63:0] busWord;
	logic        busMemWe;
	logic [63:0] busWData;

	localparam int MEM_AWX = atomic_rmw_pkg::MEM_AW;

	assign rxReady = rxReady_r;
	assign txValid = txValid_r;
	assign txData  = txData_r;
	assign dat_o   = datO_r;
	assign ack_o   = ack_r;

	// Engine: link parse, atomic execution and reply
	always_comb begin
		state_nxt    = state_r;
		idx_nxt      = idx_r;
		payIdx_nxt   = payIdx_r;
		extSeen_nxt  = extSeen_r;
		addrHi_nxt   = addrHi_r;
		addrLo_nxt   = addrLo_r;
		count_nxt    = count_r;
		stream_unit_id_nxt   = stream_unit_id_r;
		source_transaction_tag_nxt   = source_transaction_tag_r;
		opA_nxt      = opA_r;
		opB_nxt      = opB_r;
		outVal_nxt   = outVal_r;
		err_nxt      = err_r;
		doneCnt_nxt  = doneCnt_r;
		abortCnt_nxt = abortCnt_r;
		txValid_nxt  = txValid_r;
		txData_nxt   = txData_r;
		engWe        = 1'h0;
		engWData     = 64'h0;
		rxTake   = rxValid && rxReady_r;
		txTake   = txValid_r && txReady;
		payBytes = 7'({3'h0, count_r} + 7'h01) << 2;
		memOld   = mem[addrLo_r[3 +: MEM_AWX]];
		// Window compares address bits 38..7; anything higher must be zero
		inHost   = (addrHi_r == 24'h000000) && !addrLo_r[39] &&
			(addrLo_r[38:7] == window_r) &&
			({1'h0, addrLo_r[6:3]} < 5'(atomic_rmw_pkg::MEM_DEPTH));
		abortReq = !ctrl_r[atomic_rmw_pkg::CTRL_EN_BIT] || !inHost ||
			((count_r != atomic_rmw_pkg::CNT_FETCH_ADD) &&
			(count_r != atomic_rmw_pkg::CNT_CMP_SWAP));
		unique case (state_r)
			atomic_rmw_pkg::ST_CMD: begin
				if (rxTake) begin
					if (rxData[5:0] == atomic_rmw_pkg::CMD_ADDR_EXT &&
						!extSeen_r) begin
						state_nxt   = atomic_rmw_pkg::ST_EXT;
						idx_nxt     = 4'h0;
						extSeen_nxt = 1'h1;
					end else if (rxData[5:0] == atomic_rmw_pkg::CMD_ATOMIC) begin
						state_nxt = atomic_rmw_pkg::ST_HDR;
						idx_nxt   = 4'h1;
						if (!extSeen_r) begin
							addrHi_nxt = 24'h000000;
						end
					end else begin
						// A stray packet also cancels a pending extension
						extSeen_nxt = 1'h0;
						addrHi_nxt  = 24'h000000;
					end
				end
			end
			atomic_rmw_pkg::ST_EXT: begin
				if (rxTake) begin
					addrHi_nxt[idx_r[1:0]*8 +: 8] = rxData;
					idx_nxt = idx_r + 4'h1;
					if (idx_r == atomic_rmw_pkg::EXT_LAST_IDX) begin
						state_nxt = atomic_rmw_pkg::ST_CMD;
					end
				end
			end
			atomic_rmw_pkg::ST_HDR: begin
				if (rxTake) begin
					unique case (idx_r)
						4'h1: stream_unit_id_nxt = rxData[4:0];
						4'h2: begin
							count_nxt[1:0] = rxData[7:6];
							source_transaction_tag_nxt     = rxData[4:0];
						end
						4'h3: begin
							count_nxt[3:2] = rxData[1:0];
							addrLo_nxt[7:3] = rxData[7:3];
						end
						4'h4: addrLo_nxt[15:8]  = rxData;
						4'h5: addrLo_nxt[23:16] = rxData;
						4'h6: addrLo_nxt[31:24] = rxData;
						default: addrLo_nxt[39:32] = rxData;
					endcase
					idx_nxt = idx_r + 4'h1;
					if (idx_r == atomic_rmw_pkg::HDR_LAST_IDX) begin
						state_nxt  = atomic_rmw_pkg::ST_PAY;
						payIdx_nxt = 6'h00;
					end
				end
			end
			atomic_rmw_pkg::ST_PAY: begin
				if (rxTake) begin
					if (payIdx_r < 6'h08) begin
						opA_nxt[payIdx_r[2:0]*8 +: 8] = rxData;
					end else if (payIdx_r < 6'h10) begin
						opB_nxt[payIdx_r[2:0]*8 +: 8] = rxData;
					end
					payIdx_nxt = payIdx_r + 6'h01;
					if ({1'h0, payIdx_r} == payBytes - 7'h01) begin
						state_nxt = atomic_rmw_pkg::ST_EXEC;
					end
				end
			end
			atomic_rmw_pkg::ST_EXEC: begin
				// Read and write share this one cycle, so nothing intervenes
				if (abortReq) begin
					outVal_nxt   = 64'h0;
					err_nxt      = atomic_rmw_pkg::ERR_TGT_ABORT;
					abortCnt_nxt = abortCnt_r + 16'h0001;
				end else begin
					outVal_nxt  = memOld;
					err_nxt     = atomic_rmw_pkg::ERR_NONE;
					doneCnt_nxt = doneCnt_r + 16'h0001;
					if (count_r == atomic_rmw_pkg::CNT_FETCH_ADD) begin
						engWe    = 1'h1;
						engWData = memOld + opA_r;
					end else if (memOld == opA_r) begin
						engWe    = 1'h1;
						engWData = opB_r;
					end
				end
				state_nxt   = atomic_rmw_pkg::ST_RESP;
				idx_nxt     = 4'h0;
				txValid_nxt = 1'h1;
				txData_nxt  = replyByte(4'h0, stream_unit_id_r, source_transaction_tag_r, err_nxt,
					outVal_nxt);
			end
			atomic_rmw_pkg::ST_RESP: begin
				if (txTake) begin
					if (idx_r == atomic_rmw_pkg::RESP_LAST_IDX) begin
						txValid_nxt = 1'h0;
						state_nxt   = atomic_rmw_pkg::ST_CMD;
						extSeen_nxt = 1'h0;
						addrHi_nxt  = 24'h000000;
					end else begin
						idx_nxt    = idx_r + 4'h1;
						txData_nxt = replyByte(idx_r + 4'h1, stream_unit_id_r,
							source_transaction_tag_r, err_r, outVal_r);
					end
				end
			end
		endcase
		rxReady_nxt = (state_nxt != atomic_rmw_pkg::ST_EXEC) &&
			(state_nxt != atomic_rmw_pkg::ST_RESP);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r    <= atomic_rmw_pkg::ST_CMD;
			idx_r      <= 4'h0;
			payIdx_r   <= 6'h00;
			extSeen_r  <= 1'h0;
			addrHi_r   <= 24'h000000;
			addrLo_r   <= 37'h0;
			count_r    <= 4'h0;
			stream_unit_id_r   <= 5'h00;
			source_transaction_tag_r   <= 5'h00;
			opA_r      <= 64'h0;
			opB_r      <= 64'h0;
			outVal_r   <= 64'h0;
			err_r      <= 2'h0;
			doneCnt_r  <= 16'h0000;
			abortCnt_r <= 16'h0000;
			rxReady_r  <= 1'h0;
			txValid_r  <= 1'h0;
			txData_r   <= 8'h00;
		end else begin
			state_r    <= state_nxt;
			idx_r      <= idx_nxt;
			payIdx_r   <= payIdx_nxt;
			extSeen_r  <= extSeen_nxt;
			addrHi_r   <= addrHi_nxt;
			addrLo_r   <= addrLo_nxt;
			count_r    <= count_nxt;
			stream_unit_id_r   <= stream_unit_id_nxt;
			source_transaction_tag_r   <= source_transaction_tag_nxt;
			opA_r      <= opA_nxt;
			opB_r      <= opB_nxt;
			outVal_r   <= outVal_nxt;
			err_r      <= err_nxt;
			doneCnt_r  <= doneCnt_nxt;
			abortCnt_r <= abortCnt_nxt;
			rxReady_r  <= rxReady_nxt;
			txValid_r  <= txValid_nxt;
			txData_r   <= txData_nxt;
		end
	end

	// Register slave; held off during execution to keep memory locked
	always_comb begin
		ctrl_nxt   = ctrl_r;
		window_nxt = window_r;
		midx_nxt   = midx_r;
		datO_nxt   = 32'h0000_0000;
		busReq     = cyc_i && stb_i;
		ack_nxt    = busReq && !ack_r &&
			(state_r != atomic_rmw_pkg::ST_EXEC);
		busWr      = ack_nxt && we_i;
		busWord    = mem[midx_r[MEM_AWX-1:0]];
		busMemWe   = 1'h0;
		busWData   = busWord;
		unique case (adr_i)
			atomic_rmw_pkg::REG_CTRL: begin
				datO_nxt = ctrl_r;
				if (busWr) ctrl_nxt = mergeSel(ctrl_r, dat_i, sel_i);
			end
			atomic_rmw_pkg::REG_STATUS: begin
				datO_nxt = {24'h000000, atomic_rmw_pkg::IMPLIED_COHERENT,
					extSeen_r, (state_r != atomic_rmw_pkg::ST_CMD), err_r,
					3'(state_r)};
			end
			atomic_rmw_pkg::REG_WINDOW: begin
				datO_nxt = window_r;
				if (busWr) window_nxt = mergeSel(window_r, dat_i, sel_i);
			end
			atomic_rmw_pkg::REG_MIDX: begin
				datO_nxt = midx_r;
				if (busWr) midx_nxt = mergeSel(midx_r, dat_i, sel_i);
			end
			atomic_rmw_pkg::REG_MLO: begin
				datO_nxt = busWord[31:0];
				busMemWe = busWr;
				busWData[31:0] = mergeSel(busWord[31:0], dat_i, sel_i);
			end
			atomic_rmw_pkg::REG_MHI: begin
				datO_nxt = busWord[63:32];
				busMemWe = busWr;
				busWData[63:32] = mergeSel(busWord[63:32], dat_i, sel_i);
			end
			atomic_rmw_pkg::REG_COUNTS: datO_nxt = {abortCnt_r, doneCnt_r};
			default: datO_nxt = 32'h0000_0000;
		endcase
		if (!ack_nxt || we_i) begin
			datO_nxt = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r   <= atomic_rmw_pkg::CTRL_RESET;
			window_r <= atomic_rmw_pkg::WINDOW_RESET;
			midx_r   <= atomic_rmw_pkg::MIDX_RESET;
			datO_r   <= 32'h0000_0000;
			ack_r    <= 1'h0;
		end else begin
			ctrl_r   <= ctrl_nxt;
			window_r <= window_nxt;
			midx_r   <= midx_nxt;
			datO_r   <= datO_nxt;
			ack_r    <= ack_nxt;
		end
	end

	// Engine and bus never write in the same cycle
	always_ff @(posedge clk) begin
		if (engWe) begin
			mem[addrLo_r[3 +: MEM_AWX]] <= engWData;
		end else if (busMemWe) begin
			mem[midx_r[MEM_AWX-1:0]] <= busWData;
		end
	end

endmodule : atomic_rmw_target

/* File: atomic_rmw_target_sva.sv */
`timescale 1ns/1ns
module atomic_rmw_target_sva (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        rxValid,
	input wire logic [7:0]  rxData,
	input wire logic        rxReady,
	input wire logic        txValid,
	input wire logic [7:0]  txData,
	input wire logic        txReady,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o
);
	logic [3:0] txCnt_r;
	logic [3:0] txCnt_nxt;
	always_comb begin
		txCnt_nxt = txCnt_r;
		if (txValid && txReady)
			txCnt_nxt = (txCnt_r == 4'hB) ? 4'h0 : txCnt_r + 4'h1;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			txCnt_r <= 4'h0;
		else
			txCnt_r <= txCnt_nxt;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	reply_head_a: assert property (
		(txValid && txCnt_r == 4'h0) |-> txData == 8'h30)
		else $error("reply header byte wrong");
	reply_count_a: assert property (
		(txValid && txCnt_r == 4'h2) |-> txData[7:6] == 2'h1)
		else $error("reply size low bits wrong");
	count_high_a: assert property (
		(txValid && txCnt_r == 4'h3) |-> txData[1:0] == 2'h0)
		else $error("reply size high bits wrong");
	attr_bits_a: assert property (
		(txValid && txCnt_r == 4'h1) |-> txData[7:5] == 3'h2)
		else $error("reply attribute bits wrong");
	reply_hold_a: assert property (
		(txValid && !txReady) |=> txValid && $stable(txData))
		else $error("reply byte not held");
	reply_end_a: assert property (
		(txValid && txReady && txCnt_r == 4'hB) |=> !txValid ##[0:2] rxReady)
		else $error("reply not closed after twelve bytes");
	rx_locked_a: assert property (txValid |-> !rxReady)
		else $error("bytes taken while replying");
	reply_soon_a: assert property ($fell(rxReady) |-> ##[1:2] txValid)
		else $error("reply late");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_wait_a: assert property (
		(cyc_i && stb_i && !ack_o) |-> ##[1:2] ack_o)
		else $error("bus answer late");
	dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");
	cover property (txValid && txCnt_r == 4'h2 && txData[5]);
	cover property (txValid && txReady && txCnt_r == 4'hB);
	cover property (txValid && !txReady);
endmodule : atomic_rmw_target_sva
bind atomic_rmw_target atomic_rmw_target_sva u_sva (
	.clk(clk), .sys_rst(sys_rst), .rxValid(rxValid), .rxData(rxData),
	.rxReady(rxReady), .txValid(txValid), .txData(txData),
	.txReady(txReady), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o));

/* File: link_requester.sv */
`timescale 1ns/1ns
module link_requester (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       slow,
	output logic            rxValid,
	output logic [7:0]      rxData,
	input  wire logic       rxReady,
	input  wire logic       txValid,
	input  wire logic [7:0] txData,
	output logic            txReady
);
	logic [7:0] sendQ[$];
	logic [7:0] gotQ[$];
	logic       ph;
	always @(posedge clk) begin
		if (sys_rst) begin
			ph      <= 1'b0;
			txReady <= 1'b0;
			rxValid <= 1'b0;
			rxData  <= 8'h00;
		end else begin
			ph <= ~ph;
			txReady <= !slow || ph;
			if (txValid && txReady)
				gotQ.push_back(txData);
			// Bytes go out whole and in order; in slow mode an idle cycle falls between them
			if (!rxValid || rxReady) begin
				if (sendQ.size() > 0 && !(slow && ph)) begin
					rxValid <= 1'b1;
					rxData  <= sendQ.pop_front();
				end else begin
					rxValid <= 1'b0;
					// Idle line toggles so a stale byte is never mistaken
					rxData  <= ~rxData;
				end
			end
		end
	end
endmodule : link_requester

/* File: tb_atomic_rmw_target.sv */
`timescale 1ns/1ns
module tb_atomic_rmw_target;
	logic        clk;
	logic        sys_rst;
	logic        rxValid;
	logic [7:0]  rxData;
	logic        rxReady;
	logic        txValid;
	logic [7:0]  txData;
	logic        txReady;
	logic        cyc_i;
	logic        stb_i;
	logic        we_i;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        slow;
	logic [31:0] rd;
	logic [4:0]  tagS;
	logic [4:0]  tagR;
	int          errTotal;
	int          nChecks;
	int          cycles;
	atomic_rmw_target u_dut (.clk(clk), .sys_rst(sys_rst),
		.rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
		.txValid(txValid), .txData(txData), .txReady(txReady),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));
	link_requester u_req (.clk(clk), .sys_rst(sys_rst), .slow(slow),
		.rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
		.txValid(txValid), .txData(txData), .txReady(txReady));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic conclude();
		if (errTotal == 0 && nChecks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errTotal++;
			conclude();
		end
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		nChecks++;
		if (got !== exp) begin
			errTotal++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check
	// Holds the request until ack is sampled; no fixed latency assumed
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		sel_i <= 4'hF;
		dat_i <= d;
		do begin
			@(posedge clk);
		end while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic memSet(input logic [3:0] i, input logic [63:0] v);
		wb(1'b1, atomic_rmw_pkg::REG_MIDX, {28'h0, i}, rd);
		wb(1'b1, atomic_rmw_pkg::REG_MLO, v[31:0], rd);
		wb(1'b1, atomic_rmw_pkg::REG_MHI, v[63:32], rd);
	endtask : memSet
	task automatic memChk(input logic [3:0] i, input logic [63:0] v);
		logic [31:0] lo;
		wb(1'b1, atomic_rmw_pkg::REG_MIDX, {28'h0, i}, rd);
		wb(1'b0, atomic_rmw_pkg::REG_MLO, 32'h0, lo);
		wb(1'b0, atomic_rmw_pkg::REG_MHI, 32'h0, rd);
		check({rd, lo}, v);
	endtask : memChk
	task automatic req(input logic [23:0] ext, input logic [3:0] cnt,
		input logic [39:0] adr, input logic [63:0] a, input logic [63:0] b);
		logic [7:0] p[$];
		if (ext != 24'h0)
			p = {8'h3E, ext[7:0], ext[15:8], ext[23:16]};
		p.push_back({2'h0, atomic_rmw_pkg::CMD_ATOMIC});
		p.push_back(8'h05);
		p.push_back({cnt[1:0], 1'b0, tagS});
		p.push_back({adr[7:3], 1'b0, cnt[3:2]});
		for (int k = 1; k < 5; k++)
			p.push_back(adr[8*k +: 8]);
		for (int k = 0; k < (int'(cnt) + 1) * 4; k++)
			p.push_back(k < 8 ? a[8*k +: 8] : k < 16 ? b[8*k-64 +: 8] : 8'hA5);
		u_req.sendQ = {u_req.sendQ, p};
		tagS++;
	endtask : req
	task automatic reply(input logic [1:0] err, input logic [63:0] v);
		logic [95:0] r;
		while (u_req.gotQ.size() < 12) begin
			@(posedge clk);
		end
		for (int k = 0; k < 12; k++)
			r[8*k +: 8] = u_req.gotQ.pop_front();
		check({32'h0, r[31:0]}, {32'h0, 2'h0, err[1], 5'h0, 2'h1, err[0],
			tagR, 16'h4530});
		check(r[95:32], err == 2'h0 ? v : 64'h0);
		tagR++;
	endtask : reply
	task automatic tRegs();
		wb(1'b0, atomic_rmw_pkg::REG_CTRL, 32'h0, rd);
		check({32'h0, rd}, {32'h0, atomic_rmw_pkg::CTRL_RESET});
		wb(1'b0, atomic_rmw_pkg::REG_STATUS, 32'h0, rd);
		check({32'h0, rd}, 64'h0000_0000_0000_0080);
		wb(1'b1, 8'hFC, 32'hFFFF_FFFF, rd);
		wb(1'b0, 8'hFC, 32'h0, rd);
		check({32'h0, rd}, 64'h0);
	endtask : tRegs
	task automatic tFetch();
		memSet(4'h2, 64'hFFFF_FFFF_FFFF_FFFF);
		req(24'h0, atomic_rmw_pkg::CNT_FETCH_ADD, 40'h10, 64'h2, 64'h0);
		reply(2'h0, 64'hFFFF_FFFF_FFFF_FFFF);
		memChk(4'h2, 64'h1);
	endtask : tFetch
	task automatic tCas();
		slow <= 1'b1;
		memSet(4'h3, 64'h1234_5678_9ABC_DEF0);
		req(24'h0, 4'h3, 40'h18, 64'h1234_5678_9ABC_DEF0, 64'hC0DE);
		req(24'h0, 4'h3, 40'h18, 64'h1234_5678_9ABC_DEF0, 64'hBAD);
		reply(2'h0, 64'h1234_5678_9ABC_DEF0);
		reply(2'h0, 64'hC0DE);
		memChk(4'h3, 64'hC0DE);
		slow <= 1'b0;
	endtask : tCas
	task automatic tOdd();
		memSet(4'h4, 64'h77);
		req(24'h0, 4'h5, 40'h20, 64'h1, 64'h1);
		req(24'h0, 4'h1, 40'h20, 64'h1, 64'h0);
		reply(2'h1, 64'h0);
		reply(2'h0, 64'h77);
		memChk(4'h4, 64'h78);
	endtask : tOdd
	task automatic tFar();
		req(24'h00_0001, 4'h1, 40'h20, 64'h1, 64'h0);
		reply(2'h1, 64'h0);
		req(24'h0, 4'h1, 40'h80, 64'h1, 64'h0);
		reply(2'h1, 64'h0);
		wb(1'b1, atomic_rmw_pkg::REG_CTRL, 32'h0, rd);
		req(24'h0, 4'h1, 40'h20, 64'h1, 64'h0);
		reply(2'h1, 64'h0);
		wb(1'b1, atomic_rmw_pkg::REG_CTRL, 32'h1, rd);
		req(24'h0, 4'h1, 40'h20, 64'h1, 64'h0);
		reply(2'h0, 64'h78);
		memChk(4'h4, 64'h79);
		wb(1'b0, atomic_rmw_pkg::REG_COUNTS, 32'h0, rd);
		check({32'h0, rd}, 64'h0000_0000_0004_0005);
	endtask : tFar
	initial begin
		sys_rst  = 1'b1;
		cyc_i    = 1'b0;
		stb_i    = 1'b0;
		we_i     = 1'b0;
		adr_i    = 8'h00;
		sel_i    = 4'hF;
		dat_i    = 32'h0;
		slow     = 1'b0;
		tagS     = 5'h00;
		tagR     = 5'h00;
		errTotal = 0;
		nChecks  = 0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		tRegs();
		tFetch();
		tCas();
		tOdd();
		tFar();
		conclude();
	end
endmodule : tb_atomic_rmw_target
